// ### verilog/window_watchdog.sv
// Purpose: window watchdog with AHB-Lite register access
// Assumes: halt and wake strobes come from logic on clk
// Notes:   wdgResetN is the reset pin request; srst returns from the system
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
// Operation
// R1 - counter steps down once per 16384 oscillator cycles, hidden prescaler
// R2 - active watchdog pulls reset pin low ~30us when counter drops to 3Fh
// R3 - refresh while counter above window limit triggers reset
// R4 - software refreshes only between window limit and 3Fh, regularly
// R5 - software writes only C0h to FFh to the control register
// R6 - software option: off after reset, activation bit enables until reset
// R7 - hardware option: always active, activation bit ignored
// R8 - counter keeps decrementing even when watchdog inactive
// R9 - write with activation set and top bit clear resets at once
// R10 - active with halt-reset option: halt request causes reset
// R11 - six low counter bits set timeout length in 64 steps
// R12 - first decrement after write comes (LSB+128)*64 to 16384 cycles later
// R13 - timebase bits pick MSB/LSB: 4/59, 8/53, 20/35, 49/54
// R14 - software refreshes counter just before halting
// R15 - every control write must set the counter top bit
// R16 - control register resets to 7Fh
// R17 - after halt wake, counting resumes after 256 or 4096 cycles
// R18 - window check uses pre-write counter, only while active
module window_watchdog
    import wwdg_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        haltRequest,
    input  wire logic        wakeEvent,
    output logic             wdgResetN,
    output logic             watchdogActive
);
    localparam logic [9:0]  PULSE_LEN = 10'(RESET_PULSE_CYCLES - 1);
    localparam logic [11:0] WAKE_SHORT_LEN = 12'(WAKE_SHORT_CYCLES - 1);
    localparam logic [11:0] WAKE_LONG_LEN = 12'(WAKE_LONG_CYCLES - 1);

    // register state
    logic [7:0]     watchdogControl;
    logic [6:0]     windowLimit;
    logic [4:0]     cfgReg;
    logic [3:0]     cause;
    logic           hwLatched;

    // bus data phase state
    logic           dataWrite;
    logic [7:0]     dataAddr;

    // timing state
    logic [6:0]     shortAcc;
    logic [9:0]     pulseCount;
    logic           pulseActive;
    logic [11:0]    wakeCount;
    halt_state_type haltState;
    halt_state_type next_haltState;

    // decoded configuration
    wire logic [1:0]  timebase = cfgReg[CFG_TB_LSB +: 2];
    wire logic [5:0]  msbVal = msbOf(timebase);
    wire logic [5:0]  lsbVal = lsbOf(timebase);
    wire logic        haltResetOpt = cfgReg[CFG_HALTRST_BIT];
    wire logic        hwOption = hwLatched;
    wire logic [6:0]  counter = watchdogControl[6:0];

    // R12 least first period and R13 short period, both in cycles minus one
    wire logic [13:0] minFirst =
        14'(({8'h00, lsbVal} + 14'(MIN_BASE)) * 14'(LSB_SCALE) - 14'd1);
    wire logic [13:0] shortLen =
        14'(({8'h00, lsbVal} + 14'(SHORT_BASE)) * 14'(LSB_SCALE) - 14'd1);

    // activity: hardware option forces it, else the sticky bit
    wire logic active = hwOption || watchdogControl[ACTIVATE_BIT]; // R6 R7

    // address phase capture
    wire logic addrValid = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire logic readSel = addrValid && !hwrite;

    // data phase decode, if/else chain kept in one assignment each
    wire logic wrCtrl   = dataWrite && (dataAddr == CTRL_OFFSET);
    wire logic wrWindow = dataWrite && (dataAddr == WINDOW_OFFSET);
    wire logic wrConfig = dataWrite && (dataAddr == CONFIG_OFFSET);
    wire logic wrStatus = dataWrite && (dataAddr == STATUS_OFFSET);

    // reset causes from a control write
    wire logic newActivate = hwOption || watchdogControl[ACTIVATE_BIT]
                             || hwdata[ACTIVATE_BIT];
    wire logic softTrig = wrCtrl && newActivate
                          && !hwdata[TOP_BIT];                // R9 R15
    wire logic windowTrig = wrCtrl && active
                            && (counter > windowLimit);        // R3 R18

    // prescaler pacing and counter stepping
    wire logic prescRun = (haltState == RUN) || (haltState == HALT_ONE);
    wire logic tick;
    wire logic [6:0] accSum = shortAcc + 7'd4;
    wire logic nextShort = (accSum >= {1'b0, msbVal});      // R13
    wire logic stepDown = tick && !wrCtrl;                  // R8
    wire logic timeoutTrig = stepDown && active
                             && (counter == 7'h40);         // R2

    // halt handling
    wire logic haltTrig = haltRequest && active && haltResetOpt
                          && (haltState == RUN);            // R10
    wire logic haltEnter = haltRequest && !haltTrig && (haltState == RUN);

    wire logic anyTrig = softTrig || windowTrig || timeoutTrig || haltTrig;

    // read mux for address phase
    logic [31:0] readValue;
    always_comb begin
        readValue = 32'h0000_0000;
        if (haddr[7:0] == CTRL_OFFSET) begin
            readValue[7:0] = watchdogControl;
        end else if (haddr[7:0] == WINDOW_OFFSET) begin
            readValue[6:0] = windowLimit;
        end else if (haddr[7:0] == CONFIG_OFFSET) begin
            readValue[4:0] = cfgReg;
            readValue[CFG_HW_BIT] = hwLatched;
        end else if (haddr[7:0] == STATUS_OFFSET) begin
            readValue[3:0] = cause;
            readValue[ST_HALTED_BIT] = (haltState != RUN);
            readValue[ST_PULSE_BIT] = pulseActive;
        end
    end

    // zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign watchdogActive = active;

    wdg_prescaler #(
        .PRESCALE (PRESCALE)
    ) prescaler (
        .clk       (clk),
        .srst      (srst),
        .run       (prescRun),
        .reload    (wrCtrl),
        .nextShort (nextShort),
        .minFirst  (minFirst),
        .shortLen  (shortLen),
        .tick      (tick)
    ); // R1 R12

    // bus phase pipeline; read data registered at the address phase
    always_ff @(posedge clk) begin
        if (srst) begin
            dataWrite <= 1'b0;
            dataAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            dataWrite <= addrValid && hwrite;
            dataAddr <= haddr[7:0];
            if (readSel) begin
                hrdata <= readValue;
            end
        end
    end

    // control register: write wins over the step, which is then skipped
    always_ff @(posedge clk) begin
        if (srst) begin
            watchdogControl <= CTRL_RESET;                      // R16
        end else if (wrCtrl) begin
            watchdogControl[6:0] <= hwdata[6:0];                // R11
            watchdogControl[ACTIVATE_BIT] <=
                watchdogControl[ACTIVATE_BIT] || hwdata[ACTIVATE_BIT]; // R6
        end else if (stepDown) begin
            watchdogControl[6:0] <= counter - 7'd1;             // R8
        end
    end

    // window limit and configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            windowLimit <= WINDOW_RESET;
            cfgReg <= CONFIG_RESET;
            hwLatched <= CONFIG_RESET[CFG_HW_BIT];
        end else begin
            if (wrWindow) begin
                windowLimit <= hwdata[6:0];
            end
            if (wrConfig) begin
                cfgReg <= hwdata[4:0];
            end
            // hardware option can be chosen but not withdrawn by a write; only srst clears it
            if (wrConfig && hwdata[CFG_HW_BIT]) begin
                hwLatched <= 1'b1;                               // R7
            end
        end
    end

    // short-period accumulator: one short period per MSB/4 steps
    always_ff @(posedge clk) begin
        if (srst || wrCtrl) begin
            shortAcc <= 7'h00;
        end else if (stepDown) begin
            shortAcc <= nextShort ? 7'(accSum - {1'b0, msbVal}) : accSum;
        end
    end

    // sticky causes, write one to clear; a new event beats the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            cause <= 4'h0;
        end else begin
            cause[ST_WINDOW_BIT] <= windowTrig
                || (cause[ST_WINDOW_BIT] && !(wrStatus
                    && hwdata[ST_WINDOW_BIT]));
            cause[ST_TIMEOUT_BIT] <= timeoutTrig
                || (cause[ST_TIMEOUT_BIT] && !(wrStatus
                    && hwdata[ST_TIMEOUT_BIT]));
            cause[ST_SOFT_BIT] <= softTrig
                || (cause[ST_SOFT_BIT] && !(wrStatus
                    && hwdata[ST_SOFT_BIT]));
            cause[ST_HALT_BIT] <= haltTrig
                || (cause[ST_HALT_BIT] && !(wrStatus
                    && hwdata[ST_HALT_BIT]));
        end
    end

    // reset pin pulse; later triggers inside the pulse merge into it
    always_ff @(posedge clk) begin
        if (srst) begin
            pulseActive <= 1'b0;
            pulseCount <= 10'h000;
            wdgResetN <= 1'b1;
        end else if (anyTrig && !pulseActive) begin
            pulseActive <= 1'b1;
            pulseCount <= PULSE_LEN;
            wdgResetN <= 1'b0;                                  // R2
        end else if (pulseActive && pulseCount == 10'h000) begin
            pulseActive <= 1'b0;
            wdgResetN <= 1'b1;
        end else if (pulseActive) begin
            pulseCount <= pulseCount - 10'h001;
        end
    end

    // halt sequence: one more step, freeze, then delayed restart
    always_comb begin
        next_haltState = haltState;
        case (haltState)
            RUN: begin
                if (haltEnter) begin
                    next_haltState = HALT_ONE;
                end
            end
            HALT_ONE: begin
                if (wakeEvent) begin
                    next_haltState = WAKE_WAIT;
                end else if (tick) begin
                    next_haltState = HALTED;
                end
            end
            HALTED: begin
                if (wakeEvent) begin
                    next_haltState = WAKE_WAIT;
                end
            end
            default: begin
                if (wakeCount == 12'h000) begin
                    next_haltState = RUN;                       // R17
                end
            end
        endcase
    end

    // wake delay counter loaded on the wake event
    always_ff @(posedge clk) begin
        if (srst) begin
            haltState <= RUN;
            wakeCount <= 12'h000;
        end else begin
            haltState <= next_haltState;
            if (haltState != WAKE_WAIT && next_haltState == WAKE_WAIT) begin
                wakeCount <= cfgReg[CFG_WAKE_BIT] ? WAKE_LONG_LEN
                                                  : WAKE_SHORT_LEN; // R17
            end else if (haltState == WAKE_WAIT) begin
                wakeCount <= wakeCount - 12'h001;
            end
        end
    end

    // unused AHB attributes: only whole-word singles are expected
    wire logic unusedBits = ^{haddr[31:8], hsize};
endmodule

// ### inc/wwdg_pkg.sv
// Purpose: shared constants and decode helpers of the window watchdog
// Assumes: one 20 MHz clock; one oscillator cycle per clk cycle
// Notes:   register map sits on AHB-Lite, one 32-bit word per register
package wwdg_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] WINDOW_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;

    // values after reset
    localparam logic [7:0] CTRL_RESET    = 8'h7F;
    localparam logic [6:0] WINDOW_RESET  = 7'h7F;
    localparam logic [4:0] CONFIG_RESET  = 5'h00;

    // field positions
    localparam int ACTIVATE_BIT    = 7;
    localparam int TOP_BIT         = 6;
    localparam int CFG_HW_BIT      = 0;
    localparam int CFG_HALTRST_BIT = 1;
    localparam int CFG_TB_LSB      = 2;
    localparam int CFG_WAKE_BIT    = 4;
    localparam int ST_WINDOW_BIT   = 0;
    localparam int ST_TIMEOUT_BIT  = 1;
    localparam int ST_SOFT_BIT     = 2;
    localparam int ST_HALT_BIT     = 3;
    localparam int ST_HALTED_BIT   = 4;
    localparam int ST_PULSE_BIT    = 5;

    // timing
    localparam int CLK_PERIOD_NS      = 50;
    localparam int RESET_PULSE_NS     = 30000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS / CLK_PERIOD_NS < 1) ? 1
                                             : RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int PRESCALE_DEFAULT   = 16384;
    localparam int WAKE_SHORT_CYCLES  = 256;
    localparam int WAKE_LONG_CYCLES   = 4096;
    localparam int LSB_SCALE          = 64;
    localparam int MIN_BASE           = 128;
    localparam int SHORT_BASE         = 192;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [1:0] {
        RUN       = 2'b00,
        HALT_ONE  = 2'b01,
        HALTED    = 2'b10,
        WAKE_WAIT = 2'b11
    } halt_state_type;

    // timebase select to correction constants
    function automatic logic [5:0] msbOf(input logic [1:0] tb);
        case (tb)
            2'b00:   msbOf = 6'd4;
            2'b01:   msbOf = 6'd8;
            2'b10:   msbOf = 6'd20;
            default: msbOf = 6'd49;
        endcase
    endfunction

    function automatic logic [5:0] lsbOf(input logic [1:0] tb);
        case (tb)
            2'b00:   lsbOf = 6'd59;
            2'b01:   lsbOf = 6'd53;
            2'b10:   lsbOf = 6'd35;
            default: lsbOf = 6'd54;
        endcase
    endfunction

endpackage

// ### verilog/wdg_prescaler.sv
// Purpose: oscillator prescaler that paces counter decrements
// Assumes: every clk cycle is one oscillator cycle
// Notes:   phase is hidden from software; a reload only lengthens it
`timescale 1ns/10ps
module wdg_prescaler
    import wwdg_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        run,
    input  wire logic        reload,
    input  wire logic        nextShort,
    input  wire logic [13:0] minFirst,
    input  wire logic [13:0] shortLen,
    output logic             tick
);
    localparam logic [13:0] LONG_LEN = 14'(PRESCALE - 1);

    logic [13:0] remain;

    // tick when the last cycle of a period elapses
    assign tick = run && (remain == 14'h0000);

    // a write pushes the phase out to the least first period
    always_ff @(posedge clk) begin
        if (srst) begin
            remain <= LONG_LEN;
        end else if (reload && remain < minFirst) begin
            remain <= minFirst;
        end else if (tick) begin
            remain <= nextShort ? shortLen : LONG_LEN;
        end else if (run) begin
            remain <= remain - 14'h0001;
        end
    end
endmodule

// ### dv/wwdg_monitor.sv
// Purpose: port assertions of the window watchdog
// Assumes: one clk domain, srst synchronous active high
// Notes:   helpers mirror bus writes and count reset pin low cycles, never internal state
`timescale 1ns/10ps
module wwdg_monitor
    import wwdg_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        haltRequest,
    input wire logic        wdgResetN,
    input wire logic        watchdogActive
);
    logic       ctrlWr;
    logic       cfgWr;
    logic       haltOpt;
    logic [9:0] lowCnt;
    wire logic  take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;

    // data phase markers, since hwdata is only valid one cycle later
    always_ff @(posedge clk) begin
        ctrlWr <= !srst && take && haddr[7:0] == CTRL_OFFSET;
        cfgWr  <= !srst && take && haddr[7:0] == CONFIG_OFFSET;
    end

    // halt option mirror and length of the current low pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            haltOpt <= 1'b0;
            lowCnt  <= '0;
        end else begin
            if (cfgWr) haltOpt <= hwdata[CFG_HALTRST_BIT];
            lowCnt <= wdgResetN ? 10'd0 : lowCnt + 10'd1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // a pulse cut short by srst is not a pulse fault, hence the past guard
    property p_pulseLen;
        !$past(srst) && $rose(wdgResetN) |-> lowCnt == 10'(RESET_PULSE_CYCLES);
    endproperty
    a_pulseLen: assert property (p_pulseLen)
        else $error("reset pulse length wrong");

    property p_pulseMax;
        lowCnt <= 10'(RESET_PULSE_CYCLES);
    endproperty
    a_pulseMax: assert property (p_pulseMax)
        else $error("reset pulse too long");

    property p_resetState;
        disable iff (1'b0) srst |=> wdgResetN && !watchdogActive;
    endproperty
    a_resetState: assert property (p_resetState)
        else $error("state after reset wrong");

    property p_sticky;
        watchdogActive |=> watchdogActive;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("watchdog disabled without reset");

    property p_activate;
        ctrlWr && hwdata[ACTIVATE_BIT] |=> watchdogActive;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation write ignored");

    property p_hwEnable;
        cfgWr && hwdata[CFG_HW_BIT] |=> watchdogActive;
    endproperty
    a_hwEnable: assert property (p_hwEnable)
        else $error("hardware option not active");

    property p_softReset;
        ctrlWr && hwdata[ACTIVATE_BIT] && !hwdata[TOP_BIT] |-> ##[1:2] !wdgResetN;
    endproperty
    a_softReset: assert property (p_softReset)
        else $error("software reset missing");

    property p_haltReset;
        haltRequest && watchdogActive && haltOpt |-> ##[1:2] !wdgResetN;
    endproperty
    a_haltReset: assert property (p_haltReset)
        else $error("halt reset missing");

    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not okay");
endmodule

// ### dv/window_watchdog_tb.sv
// Purpose: self-checking bench of the window watchdog
// Assumes: hready loops back from hreadyout; full prescale length
// Notes:   every wait is bounded; the run stays near 40k cycles
`timescale 1ns/10ps
module window_watchdog_tb
    import wwdg_pkg::*;
    ;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } row_type;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        haltRequest = 1'b0;
    logic        wakeEvent = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        wdgResetN;
    logic        watchdogActive;
    logic [31:0] rd;
    int          miscompares = 0;
    int          numChecks = 0;
    int          n;
    // data is write data for writes, expected value for reads
    row_type     rows [8] = '{
        '{1'b0, CTRL_OFFSET,   32'h0000_007F},
        '{1'b0, WINDOW_OFFSET, 32'h0000_007F},
        '{1'b0, CONFIG_OFFSET, 32'h0000_0000},
        '{1'b0, STATUS_OFFSET, 32'h0000_0000},
        '{1'b1, 8'h10,         32'hFFFF_FFFF},
        '{1'b0, 8'h10,         32'h0000_0000},
        '{1'b1, WINDOW_OFFSET, 32'h0000_0055},
        '{1'b0, WINDOW_OFFSET, 32'h0000_0055}
    };

    always #25 clk = ~clk;

    window_watchdog #(.PRESCALE(PRESCALE_DEFAULT)) dut (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .haltRequest(haltRequest), .wakeEvent(wakeEvent),
        .wdgResetN(wdgResetN), .watchdogActive(watchdogActive)
    );

    task automatic finishTest;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail(input string msg);
        miscompares++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask

    task automatic chkPin(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) fail("output level wrong");
    endtask

    task automatic chkCnt(input int got, input int lo, input int hi);
        numChecks++;
        if (got < lo || got > hi) fail($sformatf("cycle count %0d", got));
    endtask

    // one edge with hready high ends each bus phase
    task automatic waitReady;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            fail("bus wait timed out");
            finishTest();
        end
    endtask

    // single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask

    // counts edges until the reset pin shows lvl
    task automatic waitPin(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (wdgResetN !== lvl) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) begin
                fail("reset pin wait timed out");
                finishTest();
            end
        end
    endtask

    task automatic doReset;
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        doReset();
        chkPin(wdgResetN, 1'b1);
        chkPin(watchdogActive, 1'b0);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr)
                chkReg(rd, rows[i].data);
        end
        $display("register table done");
        // one step even while disabled; two periods would be far longer
        repeat (16400) @(posedge clk);
        bus(1'b0, CTRL_OFFSET, '0);
        chkReg(rd, 32'h0000_007E);
        // active refresh below the window and above 3Fh must not reset
        bus(1'b1, WINDOW_OFFSET, 32'h0000_007F);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00FE);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00FE);
        repeat (3) @(posedge clk);
        chkPin(wdgResetN, 1'b1);
        $display("free running count done");
        // activate with top bit clear, then check the pulse
        bus(1'b1, CTRL_OFFSET, 32'h0000_00BF);
        waitPin(1'b0, 4, n);
        waitPin(1'b1, 700, n);
        chkCnt(n, RESET_PULSE_CYCLES, RESET_PULSE_CYCLES);
        chkPin(watchdogActive, 1'b1);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0004);
        doReset();
        chkPin(watchdogActive, 1'b0);
        $display("software reset done");
        // the arming write is unchecked, the early second one is not
        bus(1'b1, WINDOW_OFFSET, 32'h0000_0050);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00FF);
        repeat (3) @(posedge clk);
        chkPin(wdgResetN, 1'b1);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00FF);
        waitPin(1'b0, 4, n);
        waitPin(1'b1, 700, n);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0001);
        bus(1'b1, STATUS_OFFSET, 32'h0000_0001);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0000);
        $display("window check done");
        doReset();
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0003);
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0002);
        chkPin(watchdogActive, 1'b1);
        bus(1'b0, CONFIG_OFFSET, '0);
        chkReg(rd, 32'h0000_0003);
        haltRequest <= 1'b1;
        @(posedge clk);
        haltRequest <= 1'b0;
        waitPin(1'b0, 4, n);
        waitPin(1'b1, 700, n);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0008);
        $display("hardware option and halt done");
        // plain halt: no reset, frozen until the long wake delay ends
        doReset();
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0010);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00FF);
        haltRequest <= 1'b1;
        @(posedge clk);
        haltRequest <= 1'b0;
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0010);
        chkPin(wdgResetN, 1'b1);
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
        repeat (WAKE_LONG_CYCLES - 6) @(posedge clk);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0010);
        repeat (4) @(posedge clk);
        bus(1'b0, STATUS_OFFSET, '0);
        chkReg(rd, 32'h0000_0000);
        $display("halt and wake done");
        // load 40h late in the period, so the write stretches it to the
        // least first period of the 10 timebase, (35 + 128) * 64 cycles
        doReset();
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0009);
        repeat (7000) @(posedge clk);
        bus(1'b1, CTRL_OFFSET, 32'h0000_00C0);
        waitPin(1'b0, PRESCALE_DEFAULT + 4, n);
        chkCnt(n, (35 + MIN_BASE) * LSB_SCALE + 1,
               (35 + MIN_BASE) * LSB_SCALE + 1);
        $display("timeout done");
        finishTest();
    end
endmodule

bind window_watchdog wwdg_monitor mon (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .haltRequest(haltRequest), .wdgResetN(wdgResetN),
    .watchdogActive(watchdogActive)
);
